/* rtl/srm_pkg.sv */
`default_nettype none
package srm_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
    localparam int WD_CNT_W = 26;
    localparam int STAMP_W = 14;

    // register addresses; a register's header byte equals its address
    localparam logic [7:0] ADDR_CHAL4 = 8'h9E;
    localparam logic [7:0] ADDR_CHAL5 = 8'h9F;
    localparam logic [7:0] ADDR_BIAS = 8'hA1;
    localparam logic [7:0] ADDR_THRESH = 8'hA8;
    localparam logic [7:0] ADDR_ONE_EN = 8'hAC;
    localparam logic [7:0] ADDR_ONE_SEL = 8'hAD;
    localparam logic [7:0] ADDR_DLY_HI = 8'hAE;
    localparam logic [7:0] ADDR_DLY_LO = 8'hAF;
    localparam logic [7:0] ADDR_WDOG = 8'hB0;
    localparam logic [7:0] ADDR_PIN_DIS = 8'hB3;
    localparam logic [7:0] ADDR_SOF_HI = 8'hBA;
    localparam logic [7:0] ADDR_SOF_LO = 8'hBB;
    localparam logic [7:0] ADDR_EOF_HI = 8'hBC;
    localparam logic [7:0] ADDR_EOF_LO = 8'hBD;
    localparam logic [7:0] TEST_REG_LIMIT = 8'h9F;
    localparam logic [7:0] REG_HDR_FLAG = 8'h80;

    // reset values and fixed read bits
    localparam logic [13:0] CHAL_RST = 14'h0000;
    localparam logic [3:0] THRESH_RST = 4'h1;
    localparam logic [7:0] ONE_EN_FIXED = 8'h20;
    localparam logic [3:0] PIN_DIS_RST = 4'hF;
    localparam logic [1:0] IFACE_USB = 2'h3;

    // message headers
    localparam logic [7:0] HDR_AUTH = 8'hDF;
    localparam logic [7:0] HDR_GRAY = 8'hE0;
    localparam logic [7:0] HDR_BIN = 8'hF0;

    // image payload lengths in bytes
    localparam logic [10:0] LEN_GRAY_FULL = 11'd1536;
    localparam logic [10:0] LEN_GRAY_LOW = 11'd384;
    localparam logic [10:0] LEN_GRAY_EXT = 11'd768;
    localparam logic [10:0] LEN_BIN_FULL = 11'd384;
    localparam logic [10:0] LEN_BIN_LOW = 11'd96;

    localparam logic [3:0] DUMP_N = 4'd13;
    localparam logic [2:0] AUTH_LAST = 3'd7;

    typedef enum logic [2:0] {
        IMG_GRAY_FULL, IMG_GRAY_LOW, IMG_GRAY_EXT, IMG_BIN_FULL, IMG_BIN_LOW
    } srm_img_mode_t;

    typedef struct packed {
        logic excit_unlock;
        logic [1:0] excit;
        logic sense_unlock;
        logic [1:0] sense;
    } srm_bias_t;

    typedef struct packed {
        logic [3:0] second;
        logic [3:0] first;
    } srm_pix_t;

    // watchdog timeout in milliseconds per code
    function automatic int unsigned wd_ms(input logic [2:0] code);
        case (code)
            3'h0: wd_ms = 15;
            3'h1: wd_ms = 100;
            3'h2: wd_ms = 500;
            3'h3: wd_ms = 1000;
            3'h4: wd_ms = 2000;
            3'h5: wd_ms = 3000;
            3'h6: wd_ms = 4000;
            default: wd_ms = 5000;
        endcase
    endfunction

    // readable registers in dump order
    function automatic logic [7:0] dump_addr(input logic [3:0] idx);
        case (idx)
            4'h0: dump_addr = ADDR_CHAL4;
            4'h1: dump_addr = ADDR_BIAS;
            4'h2: dump_addr = ADDR_THRESH;
            4'h3: dump_addr = ADDR_ONE_EN;
            4'h4: dump_addr = ADDR_ONE_SEL;
            4'h5: dump_addr = ADDR_DLY_HI;
            4'h6: dump_addr = ADDR_DLY_LO;
            4'h7: dump_addr = ADDR_WDOG;
            4'h8: dump_addr = ADDR_PIN_DIS;
            4'h9: dump_addr = ADDR_SOF_HI;
            4'hA: dump_addr = ADDR_SOF_LO;
            4'hB: dump_addr = ADDR_EOF_HI;
            default: dump_addr = ADDR_EOF_LO;
        endcase
    endfunction

    // freq code 0..4 = 125k,250k,500k,1M,2M; level 0..3 = lowest..highest drive
    function automatic logic [1:0] auto_excit(input logic [2:0] f, input logic [1:0] lvl);
        logic [2:0] s;
        s = f + {1'b0, lvl};
        auto_excit = (s < 3'd3) ? 2'h0 : (s > 3'd5) ? 2'h3 : 2'(s - 3'd3);
        if (f == 3'd0) auto_excit = 2'h0;
        if (f >= 3'd4) auto_excit = (lvl == 2'h3) ? 2'h3 : 2'(lvl + 2'h1);
    endfunction

    function automatic logic [1:0] auto_sense(input logic [2:0] f);
        case (f)
            3'd0: auto_sense = 2'h0;
            3'd1: auto_sense = 2'h1;
            3'd2: auto_sense = 2'h1;
            3'd3: auto_sense = 2'h2;
            default: auto_sense = 2'h3;
        endcase
    endfunction
endpackage
`default_nettype wire

/* rtl/srm_top.sv */
// Notes on behaviour
// - writing 9Eh loads challenge bits 13..7 from data bits 6..0
// - reading 9Eh gives interface code 11 (USB) in bits 1..0
// - writing 9Fh loads challenge bits 6..0 from data bits 6..0
// - excitation bias follows frequency and drive level unless unlocked, then manual field
// - sense bias follows frequency unless unlocked, then manual field
// - finger present when measured delay exceeds four-bit threshold
// - single-register mode returns selected header and contents only
// - delay readback shows measured delay or reference per select input
// - enabled watchdog forces disconnect after timeout without USB traffic
// - timeout codes map 15ms,100ms,500ms,1s,2s,3s,4s,5s
// - pin disable bit 1 releases pin, 0 drives it; reset all 1
// - start stamp captured, or free-running and sampled on read
// - end stamp taken from free-running counter, two seven-bit halves
// - every packet starts with one message-type header byte
// - scan reset stops the outgoing stream; host resyncs that way
// - register headers 80h-BEh, histogram DEh, authentication DFh
// - gray array header E0h with 1536, 384 or 768 bytes
// - binary array header F0h with 384 or 96 bytes
// - read request returns each register preceded by its header
// - full-res gray byte holds second pixel high, first pixel low
// - registers above 9Fh dumped only when test enable is 1; single-register mode returns the selected one regardless
// - after image: auth header, word low byte first, then registers
`default_nettype none
module srm_top #(
    parameter int unsigned WD_CYC_PER_MS = srm_pkg::CLK_PER_MS
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic usb_activity,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic read_regs_req,
    input wire logic test_reg_enable,
    input wire logic scan_reset,
    input wire logic img_start,
    input wire srm_pkg::srm_img_mode_t img_mode,
    input wire logic pix_valid,
    input wire srm_pkg::srm_pix_t pix_data,
    output logic pix_ready,
    input wire logic [63:0] auth_word,
    input wire logic [9:0] measured_drive_delay,
    input wire logic [9:0] drive_reference_value,
    input wire logic ref_select,
    input wire logic freerun_select,
    input wire logic scan_start_evt,
    input wire logic scan_end_evt,
    input wire logic [2:0] meas_freq,
    input wire logic [1:0] drive_level,
    output logic [1:0] excit_bias,
    output logic [1:0] sense_bias,
    output logic finger_present,
    output logic [13:0] challenge_low,
    output logic usb_disconnect,
    input wire logic [3:0] gpio_value,
    output logic [3:0] gpio_out,
    output logic [3:0] gpio_oe
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_REG_HDR, ST_REG_DAT, ST_IMG_HDR, ST_IMG_DAT, ST_AUTH_HDR, ST_AUTH_DAT
    } srm_state_t;

    localparam int WD_CNT_W_L = srm_pkg::WD_CNT_W;

    srm_state_t st;
    srm_pkg::srm_bias_t bias;
    srm_pkg::srm_img_mode_t mode;
    logic wr_phase;
    logic [7:0] wr_addr;
    logic rdet_low;
    logic [3:0] thresh;
    logic one_en;
    logic [6:0] one_sel;
    logic wd_en;
    logic [2:0] wd_time;
    logic [3:0] pin_dis;
    logic [13:0] stamp_cnt;
    logic [13:0] sof_stamp;
    logic [13:0] eof_stamp;
    logic [WD_CNT_W_L-1:0] wd_cnt;
    logic dump_pending;
    logic one_dump;
    logic [3:0] dump_idx;
    logic [7:0] cur_addr;
    logic [10:0] img_cnt;
    logic [2:0] auth_idx;
    logic [63:0] auth_lat;
    logic tx_free;
    logic dump_take;
    logic sof_hi_read;
    logic wr_strobe;
    logic [9:0] dly_view;
    logic [WD_CNT_W_L-1:0] wd_limit;
    assign tx_free = !tx_valid || tx_ready;
    assign dump_take = (st == ST_IDLE) && !img_start && dump_pending;
    assign sof_hi_read = (st == ST_REG_DAT) && tx_free && (cur_addr == srm_pkg::ADDR_SOF_HI);
    assign wr_strobe = rx_valid && wr_phase;
    assign dly_view = ref_select ? drive_reference_value : measured_drive_delay;
    assign wd_limit = WD_CNT_W_L'(srm_pkg::wd_ms(wd_time) * WD_CYC_PER_MS);

    function automatic logic [7:0] reg_read(input logic [7:0] a);
        case (a)
            srm_pkg::ADDR_CHAL4: reg_read = {6'h00, srm_pkg::IFACE_USB};
            srm_pkg::ADDR_BIAS: reg_read = {1'b0, bias.excit_unlock, bias.excit, 1'b0,
                bias.sense_unlock, bias.sense};
            srm_pkg::ADDR_THRESH: reg_read = {1'b0, rdet_low, 2'h0, thresh};
            srm_pkg::ADDR_ONE_EN: reg_read = srm_pkg::ONE_EN_FIXED | {7'h00, one_en};
            srm_pkg::ADDR_ONE_SEL: reg_read = {1'b0, one_sel};
            srm_pkg::ADDR_DLY_HI: reg_read = {5'h00, dly_view[9:7]};
            srm_pkg::ADDR_DLY_LO: reg_read = {1'b0, dly_view[6:0]};
            srm_pkg::ADDR_WDOG: reg_read = {3'h0, wd_en, 1'b0, wd_time};
            srm_pkg::ADDR_PIN_DIS: reg_read = {4'h0, pin_dis};
            srm_pkg::ADDR_SOF_HI: reg_read = {1'b0, freerun_select ? stamp_cnt[13:7]
                : sof_stamp[13:7]};
            srm_pkg::ADDR_SOF_LO: reg_read = {1'b0, sof_stamp[6:0]};
            srm_pkg::ADDR_EOF_HI: reg_read = {1'b0, eof_stamp[13:7]};
            srm_pkg::ADDR_EOF_LO: reg_read = {1'b0, eof_stamp[6:0]};
            default: reg_read = 8'h00;
        endcase
    endfunction

    // host writes arrive as id then data; an id without bit 7 is not a register
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_phase <= 1'b0;
            wr_addr <= 8'h00;
        end else if (rx_valid) begin
            if (wr_phase) begin
                wr_phase <= 1'b0;
            end else if (rx_data[7]) begin
                wr_phase <= 1'b1;
                wr_addr <= rx_data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            challenge_low <= srm_pkg::CHAL_RST;
        end else if (wr_strobe && wr_addr == srm_pkg::ADDR_CHAL4) begin
            challenge_low[13:7] <= rx_data[6:0];
        end else if (wr_strobe && wr_addr == srm_pkg::ADDR_CHAL5) begin
            challenge_low[6:0] <= rx_data[6:0];
        end
    end

    // only the documented fields are stored, so reserved bits cannot be set
    always_ff @(posedge clk) begin
        if (srst) begin
            bias <= '0;
            rdet_low <= 1'b0;
            thresh <= srm_pkg::THRESH_RST;
            one_en <= 1'b0;
            one_sel <= 7'h00;
            wd_en <= 1'b0;
            wd_time <= 3'h0;
            pin_dis <= srm_pkg::PIN_DIS_RST;
        end else if (wr_strobe) begin
            case (wr_addr)
                srm_pkg::ADDR_BIAS: begin
                    bias <= {rx_data[6:4], rx_data[2:0]};
                end
                srm_pkg::ADDR_THRESH: begin
                    rdet_low <= rx_data[6];
                    thresh <= rx_data[3:0];
                end
                srm_pkg::ADDR_ONE_EN: begin
                    one_en <= rx_data[0];
                end
                srm_pkg::ADDR_ONE_SEL: begin
                    one_sel <= rx_data[6:0];
                end
                srm_pkg::ADDR_WDOG: begin
                    wd_en <= rx_data[4];
                    wd_time <= rx_data[2:0];
                end
                srm_pkg::ADDR_PIN_DIS: begin
                    pin_dis <= rx_data[3:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            excit_bias <= 2'h0;
            sense_bias <= 2'h0;
        end else begin
            excit_bias <= bias.excit_unlock ? bias.excit
                : srm_pkg::auto_excit(meas_freq, drive_level);
            sense_bias <= bias.sense_unlock ? bias.sense
                : srm_pkg::auto_sense(meas_freq);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            finger_present <= 1'b0;
        end else begin
            finger_present <= measured_drive_delay > {6'h00, thresh};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            gpio_oe <= 4'h0;
            gpio_out <= 4'h0;
        end else begin
            gpio_oe <= ~pin_dis;
            gpio_out <= gpio_value;
        end
    end

    // one counter serves both stamps; it wraps silently every 2^14 cycles
    always_ff @(posedge clk) begin
        if (srst) begin
            stamp_cnt <= 14'h0000;
            sof_stamp <= 14'h0000;
            eof_stamp <= 14'h0000;
        end else begin
            stamp_cnt <= stamp_cnt + 14'h0001;
            if (freerun_select) begin
                if (sof_hi_read) begin
                    sof_stamp <= stamp_cnt;
                end
            end else if (scan_start_evt) begin
                sof_stamp <= stamp_cnt;
            end
            if (scan_end_evt) begin
                eof_stamp <= stamp_cnt;
            end
        end
    end

    // any traffic for the device restarts the count
    always_ff @(posedge clk) begin
        if (srst) begin
            wd_cnt <= '0;
            usb_disconnect <= 1'b0;
        end else begin
            usb_disconnect <= 1'b0;
            if (!wd_en || usb_activity || rx_valid) begin
                wd_cnt <= '0;
            end else if (wd_cnt >= wd_limit) begin
                wd_cnt <= '0;
                usb_disconnect <= 1'b1;
            end else begin
                wd_cnt <= wd_cnt + 1'b1;
            end
        end
    end

    // set wins over the take in the same cycle
    always_ff @(posedge clk) begin
        if (srst || scan_reset) begin
            dump_pending <= 1'b0;
        end else if (read_regs_req) begin
            dump_pending <= 1'b1;
        end else if (dump_take) begin
            dump_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= ST_IDLE;
            mode <= srm_pkg::IMG_GRAY_FULL;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            pix_ready <= 1'b0;
            one_dump <= 1'b0;
            dump_idx <= 4'h0;
            cur_addr <= 8'h00;
            img_cnt <= 11'h000;
            auth_idx <= 3'h0;
            auth_lat <= 64'h0;
        end else if (scan_reset) begin
            st <= ST_IDLE;
            tx_valid <= 1'b0;
            pix_ready <= 1'b0;
        end else begin
            if (tx_valid && tx_ready) begin
                tx_valid <= 1'b0;
            end
            case (st)
                ST_IDLE: begin
                    if (img_start) begin
                        mode <= img_mode;
                        st <= ST_IMG_HDR;
                    end else if (dump_pending) begin
                        one_dump <= one_en;
                        cur_addr <= srm_pkg::REG_HDR_FLAG | {1'b0, one_sel};
                        dump_idx <= 4'h0;
                        st <= ST_REG_HDR;
                    end
                end
                ST_REG_HDR: begin
                    if (one_dump) begin
                        if (tx_free) begin
                            tx_valid <= 1'b1;
                            tx_data <= cur_addr;
                            st <= ST_REG_DAT;
                        end
                    end else if (dump_idx == srm_pkg::DUMP_N) begin
                        st <= ST_IDLE;
                    end else if (!test_reg_enable
                                 && srm_pkg::dump_addr(dump_idx) > srm_pkg::TEST_REG_LIMIT) begin
                        dump_idx <= dump_idx + 4'h1;
                    end else if (tx_free) begin
                        tx_valid <= 1'b1;
                        tx_data <= srm_pkg::dump_addr(dump_idx);
                        cur_addr <= srm_pkg::dump_addr(dump_idx);
                        st <= ST_REG_DAT;
                    end
                end
                ST_REG_DAT: begin
                    if (tx_free) begin
                        tx_valid <= 1'b1;
                        tx_data <= reg_read(cur_addr);
                        dump_idx <= dump_idx + 4'h1;
                        st <= one_dump ? ST_IDLE : ST_REG_HDR;
                    end
                end
                ST_IMG_HDR: begin
                    if (tx_free) begin
                        tx_valid <= 1'b1;
                        case (mode)
                            srm_pkg::IMG_GRAY_FULL: begin
                                tx_data <= srm_pkg::HDR_GRAY;
                                img_cnt <= srm_pkg::LEN_GRAY_FULL - 11'd1;
                            end
                            srm_pkg::IMG_GRAY_LOW: begin
                                tx_data <= srm_pkg::HDR_GRAY;
                                img_cnt <= srm_pkg::LEN_GRAY_LOW - 11'd1;
                            end
                            srm_pkg::IMG_GRAY_EXT: begin
                                tx_data <= srm_pkg::HDR_GRAY;
                                img_cnt <= srm_pkg::LEN_GRAY_EXT - 11'd1;
                            end
                            srm_pkg::IMG_BIN_FULL: begin
                                tx_data <= srm_pkg::HDR_BIN;
                                img_cnt <= srm_pkg::LEN_BIN_FULL - 11'd1;
                            end
                            default: begin
                                tx_data <= srm_pkg::HDR_BIN;
                                img_cnt <= srm_pkg::LEN_BIN_LOW - 11'd1;
                            end
                        endcase
                        st <= ST_IMG_DAT;
                    end
                end
                ST_IMG_DAT: begin
                    // pixel ready only opens with the output slot free, so no byte waits twice
                    if (pix_ready && pix_valid) begin
                        pix_ready <= 1'b0;
                        tx_valid <= 1'b1;
                        tx_data <= {pix_data.second, pix_data.first};
                        if (img_cnt == 11'h000) begin
                            st <= ST_AUTH_HDR;
                        end else begin
                            img_cnt <= img_cnt - 11'd1;
                        end
                    end else if (!pix_ready && tx_free) begin
                        pix_ready <= 1'b1;
                    end
                end
                ST_AUTH_HDR: begin
                    if (tx_free) begin
                        tx_valid <= 1'b1;
                        tx_data <= srm_pkg::HDR_AUTH;
                        auth_lat <= auth_word;
                        auth_idx <= 3'h0;
                        st <= ST_AUTH_DAT;
                    end
                end
                ST_AUTH_DAT: begin
                    if (tx_free) begin
                        tx_valid <= 1'b1;
                        tx_data <= auth_lat[{auth_idx, 3'h0} +: 8];
                        auth_idx <= auth_idx + 3'h1;
                        if (auth_idx == srm_pkg::AUTH_LAST) begin
                            one_dump <= 1'b0;
                            dump_idx <= 4'h0;
                            st <= ST_REG_HDR;
                        end
                    end
                end
                default: begin
                    st <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* bench/srm_top_monitor.sv */
`default_nettype none
module srm_top_monitor (
    input wire logic clk,
    input wire logic srst,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic usb_activity,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic scan_reset,
    input wire logic pix_ready,
    input wire logic usb_disconnect,
    input wire logic [13:0] challenge_low,
    input wire logic [3:0] gpio_value,
    input wire logic [3:0] gpio_out,
    input wire logic [3:0] gpio_oe
);
    logic pend;
    logic [7:0] id;
    // follows id/data alternation so a data byte is tied to its register
    always_ff @(posedge clk) begin
        if (srst) pend <= 1'b0;
        else if (rx_valid) pend <= !pend && rx_data[7];
    end
    always_ff @(posedge clk) begin
        if (rx_valid && !pend) id <= rx_data;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    oe_reset_a: assert property ($fell(srst) |-> gpio_oe == 4'h0)
        else $error("pins driven after reset");
    pin_copy_a: assert property (1'b1 |=> gpio_out == $past(gpio_value))
        else $error("pin copy wrong");
    tx_hold_a: assert property (
        tx_valid && !tx_ready && !scan_reset |=> tx_valid && $stable(tx_data))
        else $error("byte changed before accept");
    scan_abort_a: assert property (scan_reset |=> !tx_valid && !pix_ready)
        else $error("stream kept after scan reset");
    disc_pulse_a: assert property (usb_disconnect |=> !usb_disconnect)
        else $error("disconnect too long");
    wd_restart_a: assert property (usb_activity |=> !usb_disconnect [*8])
        else $error("disconnect right after activity");
    chal_high_a: assert property (rx_valid && pend && id == 8'h9E |-> ##2
        challenge_low[13:7] == $past(rx_data[6:0], 2)) else $error("challenge high wrong");
    chal_low_a: assert property (rx_valid && pend && id == 8'h9F |-> ##2
        challenge_low[6:0] == $past(rx_data[6:0], 2)) else $error("challenge low wrong");
endmodule
bind srm_top srm_top_monitor srm_top_monitor_inst (.*);
`default_nettype wire

/* bench/srm_host_model.sv */
`default_nettype none
module srm_host_model (
    input wire logic clk,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic got,
    output logic [7:0] got_data
);
    timeunit 1ns;
    timeprecision 1ns;
    int seed = 68;
    initial tx_ready = 1'b0;
    initial got = 1'b0;
    // stalls about one cycle in four so held bytes are exercised
    always @(posedge clk) begin
        got <= tx_valid && tx_ready;
        got_data <= tx_data;
        tx_ready <= ($random(seed) % 4) != 0;
    end
endmodule
`default_nettype wire

/* bench/srm_top_test.sv */
`default_nettype none
module srm_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, srst = 1'b1, rx_valid = 1'b0, usb_activity = 1'b0, read_regs_req = 1'b0;
    logic img_start = 1'b0, test_reg_enable = 1'b1, scan_reset = 1'b0, pix_valid = 1'b0;
    logic ref_select = 1'b0, freerun_select = 1'b0, scan_start_evt = 1'b0, scan_end_evt = 1'b0;
    logic tx_valid, tx_ready, pix_ready, got, finger_present, usb_disconnect;
    logic [7:0] rx_data = 8'h00, tx_data, got_data, a, d;
    logic [63:0] auth_word = 64'h0;
    logic [9:0] measured_drive_delay = 10'h000, drive_reference_value = 10'h000;
    logic [2:0] meas_freq = 3'h0;
    logic [1:0] drive_level = 2'h0, excit_bias, sense_bias;
    logic [13:0] challenge_low;
    logic [3:0] gpio_value = 4'h0, gpio_out, gpio_oe;
    srm_pkg::srm_img_mode_t img_mode = srm_pkg::IMG_GRAY_FULL;
    srm_pkg::srm_pix_t pix_data = 8'h00;
    logic [7:0] q[$], pq[$];
    logic [7:0] rv[13] = '{8'h03, 8'h00, 8'h01, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0F,
        8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] da[13] = '{8'h9E, 8'hA1, 8'hA8, 8'hAC, 8'hAD, 8'hAE, 8'hAF, 8'hB0, 8'hB3,
        8'hBA, 8'hBB, 8'hBC, 8'hBD};
    int len[5] = '{1536, 384, 768, 384, 96};
    int ms[9] = '{15, 100, 500, 1000, 2000, 3000, 4000, 5000, 6000};
    int se[5] = '{0, 1, 1, 2, 3};
    int seed = 68, errors = 0, cmp_count = 0, c;
    srm_top #(.WD_CYC_PER_MS(1)) srm_top_inst (.*);
    srm_host_model srm_host_model_inst (.*);
    always #50 clk = ~clk;
    always @(posedge clk) begin
        if (got) q.push_back(got_data);
        if (pix_valid && pix_ready) begin
            pq.push_back(pix_data);
            pix_data <= srm_pkg::srm_pix_t'(8'($random(seed)));
        end
        if (!pix_valid || pix_ready) pix_valid <= 1'($random(seed));
        gpio_value <= 4'($random(seed));
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    function automatic logic [1:0] ex(input int f, input int l);
        return 2'(f + l < 4 ? 0 : f + l > 5 ? 3 : f + l - 3);
    endfunction
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge clk) rx_valid <= 1'b1;
        rx_data <= ad;
        @(posedge clk) rx_data <= dt;
        @(posedge clk) rx_valid <= 1'b0;
    endtask
    task automatic req(input int n);
        q.delete();
        @(posedge clk) read_regs_req <= 1'b1;
        @(posedge clk) read_regs_req <= 1'b0;
        for (c = 0; c < 20000 && q.size() < n; c++) @(posedge clk);
        repeat (20) @(posedge clk);
        if (n > 0) chk(q.size(), n);
    endtask
    task automatic xd(input int n);
        logic [9:0] v;
        logic [7:0] m;
        v = ref_select ? drive_reference_value : measured_drive_delay;
        rv[5] = {5'h00, v[9:7]};
        rv[6] = {1'b0, v[6:0]};
        for (int i = 0; i < n; i++) begin
            m = i == 0 ? 8'h03 : i > 8 ? 8'h80 : 8'hFF;
            chk(q.pop_front(), da[i]);
            chk(q.pop_front() & m, rv[i] & m);
        end
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #(100 * 80000);
        errors++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk) #1;
        chk(gpio_oe, 4'h0);
        req(26);
        xd(13);
        $display("reset dump done");
        for (int k = 0; k < 4; k++) begin
            d = 8'($random(seed));
            a = 8'($random(seed));
            wr(8'hA8, {4'h0, d[3:0]});
            wr(8'hA1, a & 8'h77);
            wr(8'hB3, {4'h0, a[3:0]});
            wr(8'h9E, d);
            wr(8'h9F, a);
            measured_drive_delay <= 10'(d[7:3]);
            drive_reference_value <= 10'($random(seed));
            ref_select <= a[7];
            meas_freq <= 3'(k + 1);
            drive_level <= d[5:4];
            test_reg_enable <= k != 3;
            repeat (3) @(posedge clk);
            #1 chk(finger_present, measured_drive_delay > d[3:0]);
            chk(excit_bias, a[6] ? a[5:4] : ex(k + 1, d[5:4]));
            chk(sense_bias, a[2] ? a[1:0] : 2'(se[k + 1]));
            chk(gpio_oe, 4'(~a[3:0]));
            chk(challenge_low, {d[6:0], a[6:0]});
            rv[1] = a & 8'h77;
            rv[2] = {4'h0, d[3:0]};
            rv[8] = {4'h0, a[3:0]};
            req(k == 3 ? 2 : 26);
            xd(k == 3 ? 1 : 13);
        end
        test_reg_enable <= 1'b1;
        wr(8'hAC, 8'h01);
        wr(8'hAD, 8'h28);
        rv[4] = 8'h28;
        req(2);
        chk(q[0], 8'hA8);
        chk(q[1], rv[2]);
        wr(8'hAC, 8'h00);
        $display("writes done");
        for (int k = 0; k < 9; k++) begin
            wr(8'hB0, k < 8 ? 8'h10 | 8'(k) : 8'h00);
            @(posedge clk) usb_activity <= 1'b1;
            @(posedge clk) usb_activity <= 1'b0;
            for (c = 0; c < 6000 && usb_disconnect !== 1'b1; c++) @(posedge clk);
            chk(c + 1 >= ms[k] && c <= ms[k] + 3, 1'b1);
        end
        $display("watchdog done");
        for (int m = 0; m < 5; m++) begin
            pq.delete();
            q.delete();
            @(posedge clk) img_start <= 1'b1;
            img_mode <= srm_pkg::srm_img_mode_t'(m);
            auth_word <= {$random(seed), $random(seed)};
            @(posedge clk) img_start <= 1'b0;
            for (c = 0; c < 20000 && q.size() < len[m] + 36; c++) @(posedge clk);
            chk(q.pop_front(), m < 3 ? 8'hE0 : 8'hF0);
            for (int i = 0; i < len[m]; i++) chk(q.pop_front(), pq.pop_front());
            chk(q.pop_front(), 8'hDF);
            for (int i = 0; i < 8; i++) chk(q.pop_front(), auth_word[8*i+:8]);
            xd(13);
        end
        $display("images done");
        req(0);
        for (c = 0; c < 200 && q.size() < 4; c++) @(posedge clk);
        scan_reset <= 1'b1;
        @(posedge clk) scan_reset <= 1'b0;
        repeat (3) @(posedge clk);
        q.delete();
        repeat (40) @(posedge clk);
        chk(q.size(), 0);
        $display("scan reset done");
        summarize();
    end
endmodule
`default_nettype wire
